// File: design/cssc_pkg.sv
// cssc_pkg: constants for the clock source and start-up controller
// assumes fuse values are static after reset release
package cssc_pkg;
  // source kinds decoded from the select fuses
  typedef enum logic [2:0] {
    CSSC_SRC_XTAL   = 3'h0,
    CSSC_SRC_LOWF   = 3'h1,
    CSSC_SRC_RC     = 3'h2,
    CSSC_SRC_EXT    = 3'h3,
    CSSC_SRC_RSVD   = 3'h4
  } cssc_src_type;

  // reset delay kinds
  typedef enum logic [1:0] {
    CSSC_DLY_NONE = 2'h0,
    CSSC_DLY_4K   = 2'h1,
    CSSC_DLY_64K  = 2'h2,
    CSSC_DLY_RSVD = 2'h3
  } cssc_dly_type;

  // sequencer states
  typedef enum logic [2:0] {
    CSSC_ST_RESET_DLY = 3'h0,
    CSSC_ST_SRC_CNT   = 3'h1,
    CSSC_ST_RUN       = 3'h2,
    CSSC_ST_SLEEP     = 3'h3,
    CSSC_ST_HALT      = 3'h4
  } cssc_state_type;

  // fuse reset values (as shipped)
  localparam logic [3:0] CSSC_SEL_RST   = 4'h2;
  localparam logic [1:0] CSSC_SUT_RST   = 2'h2;
  localparam logic       CSSC_DIV8_RST  = 1'h0;
  // start-up counts in source cycles
  localparam logic [15:0] CSSC_CNT_6    = 16'h0006;
  localparam logic [15:0] CSSC_CNT_258  = 16'h0102;
  localparam logic [15:0] CSSC_CNT_1K   = 16'h0400;
  localparam logic [15:0] CSSC_CNT_16K  = 16'h4000;
  localparam logic [15:0] CSSC_CNT_32K  = 16'h8000;
  // watchdog oscillator counts
  localparam int CSSC_WDT_4K  = 4096;
  localparam int CSSC_WDT_64K = 65536;
endpackage

// File: design/cssc_top.sv
// cssc_top: clock source decode, clock domain enables, start-up sequencing
// assumes source and watchdog ticks and the async crystal tick are pins
`timescale 1ns/1ns
module cssc_top #(
  parameter int WDT_4K_CYC  = cssc_pkg::CSSC_WDT_4K,
  parameter int WDT_64K_CYC = cssc_pkg::CSSC_WDT_64K
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // fuses, active low programmed
  input  wire logic [3:0] clock_source_select_fuses,
  input  wire logic [1:0] startup_time_fuses,
  input  wire logic       divide_by_eight_fuse,
  // oscillator ticks from pins
  input  wire logic       source_clock_tick,
  input  wire logic       watchdog_tick,
  input  wire logic       async_crystal_tick,
  // sleep control
  input  wire logic       sleep_req,
  input  wire logic       sleep_deep,
  input  wire logic       wake_req,
  input  wire logic       async_int_pin,
  // clock domain enables
  output logic            core_clock,
  output logic            peripheral_clock,
  output logic            program_memory_clock,
  output logic            async_timer_clock,
  // status
  output logic            core_reset_n,
  output logic            load_caps_en,
  output logic [1:0]      crystal_range,
  output logic            div8_active,
  output logic            fuse_reserved,
  output logic            async_int_flag
);
  // refuse watchdog counts that the 17-bit counter cannot serve
  if (WDT_4K_CYC < 1 || WDT_64K_CYC < WDT_4K_CYC || WDT_64K_CYC > 65536) begin : g_bad_cfg
    $error("cssc_top: bad watchdog counts");
  end

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]             src_s;
    logic [1:0]             wdt_s;
    logic [1:0]             asy_s;
    logic [1:0]             ai_s;
    logic                   src_p;
    logic                   wdt_p;
    logic                   asy_p;
    logic [3:0]             sel;
    logic [1:0]             sut;
    logic                   div8;
    logic                   latched;
    cssc_pkg::cssc_state_type st;
    logic [16:0]            cnt;
    logic                   deep;
    logic                   core_en;
    logic                   per_en;
    logic                   asy_en;
    logic                   ai_flag;
  } cssc_regs_type;

  cssc_regs_type r_q;
  cssc_regs_type r_d;

  // fuse decode; zero is programmed, values used as printed
  cssc_pkg::cssc_src_type src;
  cssc_pkg::cssc_dly_type dly;
  logic [15:0]            wake_cnt;
  logic [16:0]            dly_cyc;
  logic                   src_edge;
  logic                   wdt_edge;

  always_comb begin
    src      = cssc_pkg::CSSC_SRC_RSVD;
    dly      = cssc_pkg::CSSC_DLY_RSVD;
    wake_cnt = cssc_pkg::CSSC_CNT_6;
    if (r_q.sel[3]) begin
      src = cssc_pkg::CSSC_SRC_XTAL;
    end else if (r_q.sel[2]) begin
      src = cssc_pkg::CSSC_SRC_LOWF;
    end else if (r_q.sel == 4'h2) begin
      src = cssc_pkg::CSSC_SRC_RC;
    end else if (r_q.sel == 4'h0) begin
      src = cssc_pkg::CSSC_SRC_EXT;
    end
    unique case (src)
      cssc_pkg::CSSC_SRC_XTAL: begin
        if (!r_q.sel[0]) begin
          wake_cnt = r_q.sut[1] ? cssc_pkg::CSSC_CNT_1K : cssc_pkg::CSSC_CNT_258;
          unique case (r_q.sut)
            2'h0:    dly = cssc_pkg::CSSC_DLY_4K;
            2'h1:    dly = cssc_pkg::CSSC_DLY_64K;
            2'h2:    dly = cssc_pkg::CSSC_DLY_NONE;
            2'h3:    dly = cssc_pkg::CSSC_DLY_4K;
          endcase
        end else begin
          wake_cnt = (r_q.sut == 2'h0) ? cssc_pkg::CSSC_CNT_1K : cssc_pkg::CSSC_CNT_16K;
          unique case (r_q.sut)
            2'h0:    dly = cssc_pkg::CSSC_DLY_64K;
            2'h1:    dly = cssc_pkg::CSSC_DLY_NONE;
            2'h2:    dly = cssc_pkg::CSSC_DLY_4K;
            2'h3:    dly = cssc_pkg::CSSC_DLY_64K;
          endcase
        end
      end
      cssc_pkg::CSSC_SRC_LOWF: begin
        wake_cnt = r_q.sel[0] ? cssc_pkg::CSSC_CNT_32K : cssc_pkg::CSSC_CNT_1K;
        dly = cssc_pkg::cssc_dly_type'(r_q.sut);
      end
      cssc_pkg::CSSC_SRC_RC, cssc_pkg::CSSC_SRC_EXT: begin
        wake_cnt = cssc_pkg::CSSC_CNT_6;
        dly = cssc_pkg::cssc_dly_type'(r_q.sut);
      end
      default: begin
        wake_cnt = cssc_pkg::CSSC_CNT_6;
        dly      = cssc_pkg::CSSC_DLY_RSVD;
      end
    endcase
    unique case (dly)
      cssc_pkg::CSSC_DLY_4K:  dly_cyc = 17'(WDT_4K_CYC);
      cssc_pkg::CSSC_DLY_64K: dly_cyc = 17'(WDT_64K_CYC);
      default:                dly_cyc = 17'h00000;
    endcase
  end

  // synchronised pin edges
  assign src_edge = r_q.src_s[1] & ~r_q.src_p;
  assign wdt_edge = r_q.wdt_s[1] & ~r_q.wdt_p;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_d       = r_q;
    r_d.src_s = {r_q.src_s[0], source_clock_tick};
    r_d.wdt_s = {r_q.wdt_s[0], watchdog_tick};
    r_d.asy_s = {r_q.asy_s[0], async_crystal_tick};
    r_d.ai_s  = {r_q.ai_s[0], async_int_pin};
    r_d.src_p = r_q.src_s[1];
    r_d.wdt_p = r_q.wdt_s[1];
    r_d.asy_p = r_q.asy_s[1];
    // fuses sampled once after reset release
    if (!r_q.latched) begin
      r_d.latched = 1'b1;
      r_d.sel     = clock_source_select_fuses;
      r_d.sut     = startup_time_fuses;
      r_d.div8    = divide_by_eight_fuse;
    end
    // async interrupt caught even with peripheral clock stopped
    if (r_q.ai_s[1]) begin
      r_d.ai_flag = 1'b1;
    end else if (r_q.per_en) begin
      r_d.ai_flag = 1'b0;
    end
    unique case (r_q.st)
      cssc_pkg::CSSC_ST_RESET_DLY: begin
        r_d.core_en = 1'b0;
        r_d.per_en  = 1'b0;
        if (!r_q.latched) begin
          r_d.cnt = 17'h00000;
        end else if (dly == cssc_pkg::CSSC_DLY_RSVD || src == cssc_pkg::CSSC_SRC_RSVD) begin
          r_d.st = cssc_pkg::CSSC_ST_HALT;
        end else if (r_q.cnt >= dly_cyc) begin
          r_d.st  = cssc_pkg::CSSC_ST_SRC_CNT;
          r_d.cnt = 17'h00000;
        end else if (wdt_edge) begin
          r_d.cnt = r_q.cnt + 17'h00001;
        end
      end
      cssc_pkg::CSSC_ST_SRC_CNT: begin
        if (r_q.cnt >= {1'b0, wake_cnt}) begin
          r_d.st      = cssc_pkg::CSSC_ST_RUN;
          r_d.core_en = 1'b1;
          r_d.per_en  = 1'b1;
          r_d.cnt     = 17'h00000;
        end else if (src_edge) begin
          r_d.cnt = r_q.cnt + 17'h00001;
        end
      end
      cssc_pkg::CSSC_ST_RUN: begin
        if (sleep_req) begin
          r_d.st      = cssc_pkg::CSSC_ST_SLEEP;
          r_d.deep    = sleep_deep;
          r_d.core_en = 1'b0;
          r_d.per_en  = ~sleep_deep;
        end
      end
      cssc_pkg::CSSC_ST_SLEEP: begin
        if (wake_req || r_q.ai_flag) begin
          if (r_q.deep) begin
            r_d.st  = cssc_pkg::CSSC_ST_SRC_CNT;
            r_d.cnt = 17'h00000;
          end else begin
            r_d.st      = cssc_pkg::CSSC_ST_RUN;
            r_d.core_en = 1'b1;
            r_d.per_en  = 1'b1;
          end
        end
      end
      cssc_pkg::CSSC_ST_HALT: begin
        r_d.core_en = 1'b0;
        r_d.per_en  = 1'b0;
      end
      default: begin
        r_d.st = cssc_pkg::CSSC_ST_HALT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r_q         <= '0;
      r_q.st      <= cssc_pkg::CSSC_ST_RESET_DLY;
      r_q.sel     <= cssc_pkg::CSSC_SEL_RST;
      r_q.sut     <= cssc_pkg::CSSC_SUT_RST;
      r_q.div8    <= cssc_pkg::CSSC_DIV8_RST;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign core_clock           = r_q.core_en;
  assign program_memory_clock = r_q.core_en;
  assign peripheral_clock     = r_q.per_en;
  assign async_timer_clock    = r_q.asy_s[1] & ~r_q.asy_p;
  assign core_reset_n         = r_q.st != cssc_pkg::CSSC_ST_RESET_DLY
                             && r_q.st != cssc_pkg::CSSC_ST_HALT
                             && !(r_q.st == cssc_pkg::CSSC_ST_SRC_CNT && !r_q.deep);
  assign load_caps_en   = (src == cssc_pkg::CSSC_SRC_LOWF) && r_q.sel[1];
  assign crystal_range  = (src == cssc_pkg::CSSC_SRC_XTAL) ? r_q.sel[2:1] : 2'h0;
  assign div8_active    = ~r_q.div8;
  assign fuse_reserved  = (src == cssc_pkg::CSSC_SRC_RSVD) || (dly == cssc_pkg::CSSC_DLY_RSVD);
  assign async_int_flag = r_q.ai_flag;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_delay_done;
    r_q.st == cssc_pkg::CSSC_ST_RESET_DLY ##1 r_q.st == cssc_pkg::CSSC_ST_SRC_CNT;
  endsequence

  // wake from deep sleep, by request or by the async pin
  sequence s_deep_wake;
    r_q.st == cssc_pkg::CSSC_ST_SLEEP && r_q.deep && (wake_req || r_q.ai_flag);
  endsequence

  // normal operation
  sequence s_in_run;
    r_q.st == cssc_pkg::CSSC_ST_RUN;
  endsequence

  AST_ORDER: assert property (@(posedge mclk) disable iff (!reset_n)
    s_delay_done |-> !core_reset_n)
    else $error("core left reset before source count");
  AST_PMEM: assert property (@(posedge mclk) disable iff (!reset_n)
    program_memory_clock == core_clock)
    else $error("program memory clock differs from core");
  AST_CAPS: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.latched && r_q.sel[3:1] == 3'h3) |-> load_caps_en)
    else $error("load capacitors not enabled");
  AST_CAPS_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.sel[3:1] == 3'h2) |-> !load_caps_en)
    else $error("load capacitors enabled wrongly");
  AST_SLEEP: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == cssc_pkg::CSSC_ST_RUN && sleep_req) |=> !core_clock)
    else $error("core clock ran in sleep");
  AST_WAKE: assert property (@(posedge mclk) disable iff (!reset_n)
    s_deep_wake |=> !core_clock [*2])
    else $error("deep wake skipped start-up count");
  AST_RC6: assert property (@(posedge mclk) disable iff (!reset_n)
    (src == cssc_pkg::CSSC_SRC_RC) |-> wake_cnt == 16'h0006)
    else $error("RC wake count not six");
  AST_DIV8: assert property (@(posedge mclk) disable iff (!reset_n)
    div8_active == !r_q.div8)
    else $error("fuse polarity wrong");
  AST_AINT: assert property (@(posedge mclk) disable iff (!reset_n)
    r_q.ai_s[1] |=> async_int_flag)
    else $error("async interrupt lost");

  ////////////////////////////////////////////////////////////////////////
  // further checks on decode and sequencing

  // core out of reset whenever running
  AST_RUN_OUT: assert property (@(posedge mclk) disable iff (!reset_n)
    s_in_run |-> core_reset_n)
    else $error("core held in reset while running");

  // halted on reserved fuses: core held in reset, core and peripheral clocks stopped
  AST_HALT_RSV: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == cssc_pkg::CSSC_ST_HALT) |-> (!core_reset_n && !core_clock && !peripheral_clock))
    else $error("halt state let the core run");

  // reserved fuse code leads to halt
  AST_RSV_HALT: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.latched && r_q.st == cssc_pkg::CSSC_ST_RESET_DLY && fuse_reserved)
      |=> r_q.st == cssc_pkg::CSSC_ST_HALT)
    else $error("reserved fuses not halted");

  // crystal range follows the upper select bits
  AST_XRANGE: assert property (@(posedge mclk) disable iff (!reset_n)
    r_q.sel[3] |-> crystal_range == r_q.sel[2:1])
    else $error("crystal range wrong");

  // low-frequency crystal, long wake count
  AST_LOWF_WAKE: assert property (@(posedge mclk) disable iff (!reset_n)
    (src == cssc_pkg::CSSC_SRC_LOWF && r_q.sel[0]) |-> wake_cnt == cssc_pkg::CSSC_CNT_32K)
    else $error("low-frequency wake count wrong");

  // low-frequency crystal, reserved delay code
  AST_LOWF_DLY: assert property (@(posedge mclk) disable iff (!reset_n)
    (src == cssc_pkg::CSSC_SRC_LOWF && r_q.sut == 2'h3) |-> fuse_reserved)
    else $error("reserved delay code accepted");

  // crystal, resonator row without added delay
  AST_XTAL_NONE: assert property (@(posedge mclk) disable iff (!reset_n)
    (src == cssc_pkg::CSSC_SRC_XTAL && !r_q.sel[0] && r_q.sut == 2'h2) |-> dly_cyc == 17'h00000)
    else $error("crystal delay not zero");

  // reset delay counter only moves on watchdog edges
  AST_DLY_CNT: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == cssc_pkg::CSSC_ST_RESET_DLY && r_q.latched && !fuse_reserved
      && r_q.cnt < dly_cyc && !wdt_edge) |=> $stable(r_q.cnt))
    else $error("reset delay counted without watchdog edge");

  // source count not left early
  AST_SRC_CNT: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == cssc_pkg::CSSC_ST_SRC_CNT && r_q.cnt < {1'b0, wake_cnt})
      |=> r_q.st == cssc_pkg::CSSC_ST_SRC_CNT)
    else $error("start-up count cut short");

  // light sleep keeps the peripheral domain
  AST_PER_SLEEP: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == cssc_pkg::CSSC_ST_SLEEP && !r_q.deep) |-> peripheral_clock)
    else $error("peripheral clock stopped in light sleep");

  // deep sleep stops the peripheral domain
  AST_DEEP_PER: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == cssc_pkg::CSSC_ST_SLEEP && r_q.deep) |-> !peripheral_clock)
    else $error("peripheral clock ran in deep sleep");

  // core never runs without the peripheral domain
  AST_CORE_PER: assert property (@(posedge mclk) disable iff (!reset_n)
    core_clock |-> peripheral_clock)
    else $error("core clock without peripheral clock");

  // async timer tick is a single-cycle pulse
  AST_ASY_PULSE: assert property (@(posedge mclk) disable iff (!reset_n)
    async_timer_clock |=> !async_timer_clock)
    else $error("async timer tick too long");
endmodule

// File: tb/cssc_osc_model.sv
// cssc_osc_model: free-running oscillator pins at the controller's far side
// assumes the controller samples each pin through its own synchronizer
`timescale 1ns/1ns
module cssc_osc_model #(
  parameter int SRC_HALF = 20,
  parameter int WDT_HALF = 30,
  parameter int ASY_HALF = 50
) (
  // oscillator pins
  output logic source_clock_tick,
  output logic watchdog_tick,
  output logic async_crystal_tick
);
  // main source; the lowest crystal range is a resonator here, not quartz
  initial begin
    source_clock_tick = 1'b0;
    forever #(SRC_HALF) source_clock_tick = ~source_clock_tick;
  end
  // watchdog oscillator that times the reset delay
  initial begin
    watchdog_tick = 1'b0;
    forever #(WDT_HALF) watchdog_tick = ~watchdog_tick;
  end
  // 32 kHz watch crystal, keeps running through sleep
  initial begin
    async_crystal_tick = 1'b0;
    forever #(ASY_HALF) async_crystal_tick = ~async_crystal_tick;
  end
endmodule

// File: tb/cssc_top_test.sv
// cssc_top_test: start-up tables, fuse decode and sleep/wake of cssc_top
// assumes source period 4, watchdog period 6, crystal period 10 mclk cycles
`timescale 1ns/1ns
module cssc_top_test;
  typedef struct {
    logic [8:0] bits;
    logic [8:0] mask;
    int         lo;
    int         hi;
  } cssc_note_type;

  logic       mclk;
  logic       reset_n;
  logic [3:0] clock_source_select_fuses;
  logic [1:0] startup_time_fuses;
  logic       divide_by_eight_fuse;
  logic       sleep_req;
  logic       sleep_deep;
  logic       wake_req;
  logic       async_int_pin;
  wire        source_clock_tick;
  wire        watchdog_tick;
  wire        async_crystal_tick;
  wire        core_clock;
  wire        peripheral_clock;
  wire        program_memory_clock;
  wire        async_timer_clock;
  wire        core_reset_n;
  wire        load_caps_en;
  wire  [1:0] crystal_range;
  wire        div8_active;
  wire        fuse_reserved;
  wire        async_int_flag;
  wire        seen;
  logic       seen_q;
  int         cyc;
  int         err_count;
  int         tests_run;
  int         seed;
  cssc_note_type exp_q[$];

  ////////////////////////////////////////////////////////////////////////////
  // design and far side
  cssc_top #(.WDT_4K_CYC(4), .WDT_64K_CYC(16)) u_cssc_top (
    .mclk(mclk), .reset_n(reset_n),
    .clock_source_select_fuses(clock_source_select_fuses),
    .startup_time_fuses(startup_time_fuses),
    .divide_by_eight_fuse(divide_by_eight_fuse),
    .source_clock_tick(source_clock_tick), .watchdog_tick(watchdog_tick),
    .async_crystal_tick(async_crystal_tick), .sleep_req(sleep_req),
    .sleep_deep(sleep_deep), .wake_req(wake_req), .async_int_pin(async_int_pin),
    .core_clock(core_clock), .peripheral_clock(peripheral_clock),
    .program_memory_clock(program_memory_clock),
    .async_timer_clock(async_timer_clock), .core_reset_n(core_reset_n),
    .load_caps_en(load_caps_en), .crystal_range(crystal_range),
    .div8_active(div8_active), .fuse_reserved(fuse_reserved),
    .async_int_flag(async_int_flag)
  );
  cssc_osc_model u_cssc_osc_model (
    .source_clock_tick(source_clock_tick), .watchdog_tick(watchdog_tick),
    .async_crystal_tick(async_crystal_tick)
  );

  // clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare and verdict
  task automatic check(input string what, input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watcher: a start-up result is matched to the oldest note
  assign seen = core_reset_n | fuse_reserved;
  always @(posedge mclk) begin
    cssc_note_type n;
    cyc <= reset_n ? cyc + 1 : 0;
    seen_q <= seen;
    if (seen && !seen_q && exp_q.size() > 0) begin
      n = exp_q.pop_front();
      check("decode", {fuse_reserved, load_caps_en, crystal_range, div8_active, core_reset_n,
            core_clock, program_memory_clock, peripheral_clock} & n.mask,
            n.bits & n.mask);
      if (!fuse_reserved) check("startup_time", 9'(cyc >= n.lo && cyc <= n.hi), 9'h001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one start-up from reset with given fuses, w watchdog and s source ticks
  task automatic run_case(input logic [3:0] sel, input logic [1:0] sut, input int w, input int s);
    cssc_note_type n;
    logic rsv;
    int r;
    int k;
    r = $random(seed);
    rsv = (sel == 4'h3) || (sel == 4'h1);
    n.bits = {rsv, sel[3:1] == 3'h3, sel[2:1], ~r[0], {4{~rsv}}};
    n.mask = {2'h3, {2{sel[3]}}, 5'h1F};
    n.lo = w * 6 + s * 4 - 12;
    n.hi = w * 6 + s * 4 + 30;
    @(posedge mclk);
    reset_n <= 1'b0;
    clock_source_select_fuses <= sel;
    startup_time_fuses <= sut;
    divide_by_eight_fuse <= r[0];
    repeat (4) @(posedge mclk);
    check("in_reset", {div8_active, fuse_reserved, core_reset_n, core_clock}, 9'h008);
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    exp_q.push_back(n);
    for (k = 0; k < n.hi + 20 && exp_q.size() > 0; k++) @(posedge mclk);
    if (exp_q.size() > 0) begin
      err_count++;
      report_and_stop();
    end
  endtask

  // sleep, let the crystal run, wake by request or by the async pin
  task automatic sleep_wake(input logic deep, input logic by_pin);
    int k;
    int asy;
    @(posedge mclk);
    sleep_req <= 1'b1;
    sleep_deep <= deep;
    @(posedge mclk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge mclk);
    check("sleep_clocks", {core_clock, program_memory_clock, peripheral_clock}, {2'h0, ~deep});
    asy = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge mclk);
      asy += 32'(async_timer_clock);
    end
    check("async_ticks", 9'(asy >= 3 && asy <= 5), 9'h001);
    if (by_pin) async_int_pin <= 1'b1;
    else wake_req <= 1'b1;
    @(posedge mclk);
    wake_req <= 1'b0;
    for (k = 0; k < 60 && core_clock !== 1'b1; k++) @(posedge mclk);
    check("wake_time", 9'(k >= (deep ? 14 : 0) && k < 60), 9'h001);
    check("wake_state", {core_reset_n, async_int_flag}, {1'b1, by_pin});
    async_int_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    check("flag_clear", async_int_flag, 9'h000);
  endtask

  // main sequence
  initial begin
    seed = 18111;
    err_count = 0;
    tests_run = 0;
    reset_n = 1'b0;
    clock_source_select_fuses = 4'h2;
    startup_time_fuses = 2'h2;
    divide_by_eight_fuse = 1'b0;
    sleep_req = 1'b0;
    sleep_deep = 1'b0;
    wake_req = 1'b0;
    async_int_pin = 1'b0;
    run_case(4'h2, 2'h2, 16, 6);
    run_case(4'h0, 2'h0, 0, 6);
    run_case(4'h0, 2'h1, 4, 6);
    run_case(4'h2, 2'h1, 4, 6);
    run_case(4'h8, 2'h0, 4, 258);
    run_case(4'hA, 2'h1, 16, 258);
    run_case(4'hC, 2'h2, 0, 1024);
    run_case(4'hE, 2'h3, 4, 1024);
    run_case(4'h9, 2'h0, 16, 1024);
    run_case(4'h6, 2'h1, 4, 1024);
    run_case(4'h4, 2'h0, 0, 1024);
    run_case(4'h3, 2'h0, 0, 0);
    run_case(4'h1, 2'h2, 0, 0);
    run_case(4'h2, 2'h2, 16, 6);
    sleep_wake(1'b0, 1'b0);
    sleep_wake(1'b1, 1'b1);
    report_and_stop();
  end
endmodule
